//--- verilog/aoc_pkg.sv
// Constants shared by the actuator output protection controller.
package aoc_pkg;
  // Clock and filter timing.
  localparam int CLK_NS = 8;
  localparam int DIAG_FILTER_NS = 32000;
  localparam int DIAG_CYC = (DIAG_FILTER_NS + CLK_NS - 1) / CLK_NS;
  localparam int OPEN_LOAD_FILTER_NS = 1000000;
  localparam int OPEN_LOAD_CYC = (OPEN_LOAD_FILTER_NS + CLK_NS - 1) / CLK_NS;
  localparam int XPROT_NS = 1000;
  localparam int XPROT_CYC = (XPROT_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOV_SHORT_NS = 96000;
  localparam int RECOV_SHORT_CYC = RECOV_SHORT_NS / CLK_NS;
  localparam int RECOV_LONG_NS = 224000;
  localparam int RECOV_LONG_CYC = RECOV_LONG_NS / CLK_NS;
  localparam int RECOV_W = 15;
  // Sizes.
  localparam int NUM_OUT = 11;
  localparam int NUM_BRIDGE = 6;
  localparam int NUM_HSD = 5;
  localparam int REG_W = 24;
  // Register byte offsets.
  localparam logic [7:0] CTRL0_OFS = 8'h00;
  localparam logic [7:0] CTRL1_OFS = 8'h04;
  localparam logic [7:0] STAT0_OFS = 8'h08;
  localparam logic [7:0] STAT1_OFS = 8'h0c;
  localparam logic [REG_W-1:0] CTRL_RST = 24'h000000;
  // First control register fields.
  localparam int DRV_CMD_LO = 1;
  localparam int HSD_CMD_LO = 13;
  localparam int MON_SEL_LO = 18;
  localparam int SUP_RECDIS_BIT = 20;
  localparam int MON_LAST_BIT = 21;
  localparam int STAT_CLR_BIT = 22;
  localparam int ACTIVE_BIT = 23;
  // Second control register fields.
  localparam int PWM_EN_LO = 1;
  localparam int OC_REC_LO = 12;
  localparam int REC_LONG_BIT = 23;
  // Status register fields.
  localparam int FAULT_BIT = 0;
  localparam int OC_LO = 1;
  localparam int UV_BIT = 20;
  localparam int OV_BIT = 21;
  localparam int TW_BIT = 22;
  localparam int OL_LO = 1;
  localparam int TSD_BIT = 12;
endpackage : aoc_pkg

//--- verilog/aoc_bridge_if.sv
// Request and drive signals between the controller and one half bridge.
`timescale 1ns/1ps
interface aoc_bridge_if;
  logic reqHs;
  logic reqLs;
  logic hsOn;
  logic lsOn;
  logic hsFast;
  logic lsFast;
  modport ctrl (output reqHs, output reqLs, input hsOn, input lsOn, input hsFast, input lsFast);
  modport bridge (input reqHs, input reqLs, output hsOn, output lsOn, output hsFast, output lsFast);
endinterface : aoc_bridge_if

//--- verilog/aoc_filter.sv
// Diagnostic persistence filter with restart on a dropped condition.
`timescale 1ns/1ps
module aoc_filter #(
  parameter int CYC = 4000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Condition and result
  input wire logic cond,
  output logic qual,
  output logic hit
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);
  logic [CW-1:0] cnt;

  always_ff @(posedge sys_clk) begin
    if (srst || !cond) begin
      cnt <= '0;
      qual <= 1'b0;
      hit <= 1'b0;
    end else begin
      hit <= (cnt == LAST) && !qual;
      if (cnt == LAST) begin
        qual <= 1'b1;
      end else begin
        cnt <= cnt + CW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_restart;
    @(posedge sys_clk) disable iff (srst) cond ##1 !cond |=> !qual && (cnt == '0);
  endproperty
  a_restart: assert property (p_restart) else $error("filter did not restart");
  property p_hold;
    @(posedge sys_clk) disable iff (srst) $rose(qual) |-> $past(cnt) == LAST && $past(cond);
  endproperty
  a_hold: assert property (p_hold) else $error("filter qualified early");
endmodule : aoc_filter

//--- verilog/aoc_xbridge.sv
// Half bridge sequencer with cross-current dead time and fast turn-off.
`timescale 1ns/1ps
module aoc_xbridge (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Bridge requests and drives
  aoc_bridge_if.bridge br
);
  typedef enum logic [1:0] {XB_IDLE = 2'b00, XB_HON = 2'b01, XB_DEAD = 2'b11, XB_LON = 2'b10} aoc_xb_t;
  localparam int CW = $clog2(aoc_pkg::XPROT_CYC + 1);
  aoc_xb_t state;
  logic [CW-1:0] dead;
  logic fromHs;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= XB_IDLE;
      dead <= '0;
      fromHs <= 1'b0;
      br.hsOn <= 1'b0;
      br.lsOn <= 1'b0;
      br.hsFast <= 1'b0;
      br.lsFast <= 1'b0;
    end else begin
      br.hsFast <= 1'b0;
      br.lsFast <= 1'b0;
      case (state)
        XB_IDLE: begin
          if (br.reqHs && !br.reqLs) begin
            state <= XB_HON;
            br.hsOn <= 1'b1;
          end else if (br.reqLs && !br.reqHs) begin
            state <= XB_LON;
            br.lsOn <= 1'b1;
          end
        end
        XB_HON: begin
          if (!br.reqHs || br.reqLs) begin
            state <= XB_DEAD;
            br.hsOn <= 1'b0;
            fromHs <= 1'b1;
            dead <= CW'(aoc_pkg::XPROT_CYC - 1);
          end
        end
        XB_LON: begin
          if (!br.reqLs || br.reqHs) begin
            state <= XB_DEAD;
            br.lsOn <= 1'b0;
            fromHs <= 1'b0;
            dead <= CW'(aoc_pkg::XPROT_CYC - 1);
          end
        end
        XB_DEAD: begin
          if (dead == '0) begin
            state <= XB_IDLE;
            br.hsFast <= fromHs;
            br.lsFast <= !fromHs;
          end else begin
            dead <= dead - CW'(1);
          end
        end
        default: begin
          state <= XB_IDLE;
          br.hsOn <= 1'b0;
          br.lsOn <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_no_shoot;
    @(posedge sys_clk) disable iff (srst) !(br.hsOn && br.lsOn);
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("both sides on");
  property p_dead;
    @(posedge sys_clk) disable iff (srst) $fell(br.hsOn) |-> !br.lsOn [*8];
  endproperty
  a_dead: assert property (p_dead) else $error("opposite side on too soon");
  sequence s_release;
    ##[124:126] br.hsFast;
  endsequence
  property p_release;
    @(posedge sys_clk) disable iff (srst) $fell(br.hsOn) |-> s_release;
  endproperty
  a_release: assert property (p_release) else $error("fast turn-off missed");
endmodule : aoc_xbridge

//--- verilog/aoc_ctrl.sv
// Output control and protection logic of the multi-output actuator driver.
//
// Behaviour
// - Active bit cleared enters standby
// - Standby clears latches, all pins released
// - Active bit set enters active mode
// - Supply and temperature faults filtered 32 us
// - Open load, warning never change drivers
// - Overload stops one driver, shutdown all
// - Without recovery, overcurrent latches driver off
// - Overvoltage forces all eleven outputs off
// - Undervoltage forces output stages off
// - Supply restored, outputs resume when allowed
// - Recovery disabled: software must clear status
// - Temperature warning flag readable by software
// - Shutdown clears only after cooling plus software
// - Open load flagged after 1 ms
// - Overcurrent 32 us flags and stops driver
// - Select bits choose monitored high side
// - PWM enable ANDs pulse input, control
// - Outputs nine, ten use second pulse pin
// - Opposite transistor waits cross-current time
// - Departing side fast-off, opposite slew-limited on
// - Control bits one to seventeen drive outputs
// - Clear bit wipes both status registers, shutdown only once cooled
// - Recovery bit retries output after delay
// - Never both transistors of a bridge
`timescale 1ns/1ps
module aoc_ctrl #(
  parameter int OPEN_LOAD_CYC = aoc_pkg::OPEN_LOAD_CYC,
  parameter int RECOV_SHORT_CYC = aoc_pkg::RECOV_SHORT_CYC,
  parameter int RECOV_LONG_CYC = aoc_pkg::RECOV_LONG_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Comparator inputs
  input wire logic overvoltageCmp,
  input wire logic undervoltageCmp,
  input wire logic tempWarnCmp,
  input wire logic thermalShutdownCmp,
  input wire logic thermalCooledCmp,
  input wire logic [10:0] overcurrentCmp,
  input wire logic [10:0] openLoadCmp,
  // Pulse gate pins
  input wire logic pulseGateInputA,
  input wire logic monitorPulseSharedPinIn,
  output logic monitorPulseSharedPinOut,
  output logic monitorPulseSharedPinOe_n,
  output logic [3:0] monitorSelect,
  // Driver stages
  output logic [5:0] highSideTransistor,
  output logic [5:0] lowSideTransistor,
  output logic [5:0] highSideFastOff,
  output logic [5:0] lowSideFastOff,
  output logic [4:0] highsideOutput
);
  localparam int NO = aoc_pkg::NUM_OUT;
  localparam int NB = aoc_pkg::NUM_BRIDGE;
  localparam int NH = aoc_pkg::NUM_HSD;
  localparam int RW = aoc_pkg::RECOV_W;
  localparam int SW = 29;
  localparam int NF = 4 + 2 * NO;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: syncA feeds only syncB.
  logic [SW-1:0] rawIn;
  logic [SW-1:0] syncA;
  logic [SW-1:0] syncB;
  assign rawIn = {monitorPulseSharedPinIn, pulseGateInputA, openLoadCmp, overcurrentCmp,
                  thermalCooledCmp, thermalShutdownCmp, tempWarnCmp, undervoltageCmp,
                  overvoltageCmp};
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      syncA <= '0;
      syncB <= '0;
    end else begin
      syncA <= rawIn;
      syncB <= syncA;
    end
  end
  logic coolS;
  logic pulseA;
  logic pulseB;
  logic [NO-1:0] ocS;
  logic [NO-1:0] olS;
  assign coolS = syncB[4];
  assign ocS = syncB[15:5];
  assign olS = syncB[26:16];
  assign pulseA = syncB[27];
  assign pulseB = syncB[28] && monitorPulseSharedPinOe_n;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus.
  logic [23:0] ctrl0;
  logic [23:0] ctrl1;
  logic [23:0] stat0;
  logic [23:0] stat1;
  logic actv;
  logic wrCtrl0;
  logic wrCtrl1;
  logic clrReq;
  logic apbSetup;
  logic apbWrite;
  assign actv = ctrl0[aoc_pkg::ACTIVE_BIT];
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pready && pwrite;
  assign wrCtrl0 = apbWrite && paddr == aoc_pkg::CTRL0_OFS;
  assign wrCtrl1 = apbWrite && paddr == aoc_pkg::CTRL1_OFS;
  assign clrReq = wrCtrl0 && pwdata[aoc_pkg::STAT_CLR_BIT];

  function automatic logic addrKnown(input logic [7:0] a);
    addrKnown = a == aoc_pkg::CTRL0_OFS || a == aoc_pkg::CTRL1_OFS ||
                a == aoc_pkg::STAT0_OFS || a == aoc_pkg::STAT1_OFS;
  endfunction : addrKnown

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apbSetup;
      pslverr <= apbSetup && !addrKnown(paddr);
      prdata <= 32'h00000000;
      if (apbSetup && !pwrite) begin
        case (paddr)
          aoc_pkg::CTRL0_OFS: prdata <= {8'h00, ctrl0};
          aoc_pkg::CTRL1_OFS: prdata <= {8'h00, ctrl1};
          aoc_pkg::STAT0_OFS: prdata <= {8'h00, stat0};
          aoc_pkg::STAT1_OFS: prdata <= {8'h00, stat1};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl0 <= aoc_pkg::CTRL_RST;
    end else if (wrCtrl0) begin
      ctrl0 <= pwdata[aoc_pkg::ACTIVE_BIT] ? pwdata[23:0] & ~(24'h000001 << aoc_pkg::STAT_CLR_BIT)
                                           : aoc_pkg::CTRL_RST;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst || !actv) begin
      ctrl1 <= aoc_pkg::CTRL_RST;
    end else if (wrCtrl1) begin
      ctrl1 <= pwdata[23:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Diagnostic filters: supply and temperature, then overcurrent, then open load.
  logic [NO-1:0] drvOn;
  logic [NF-1:0] fCond;
  logic [NF-1:0] fLvl;
  logic [NF-1:0] fHit;
  assign fCond = {olS & drvOn, ocS, syncB[3:0]};
  for (genvar i = 0; i < NF; i++) begin : g_filt
    aoc_filter #(.CYC(i >= 4 + NO ? OPEN_LOAD_CYC : aoc_pkg::DIAG_CYC)) u_filt (
      .sys_clk(sys_clk),
      .srst(srst),
      .cond(fCond[i]),
      .qual(fLvl[i]),
      .hit(fHit[i])
    );
  end

  logic ovSt;
  logic uvSt;
  logic twSt;
  logic tsdSt;
  logic [NO-1:0] ocSt;
  logic [NO-1:0] olSt;
  always_ff @(posedge sys_clk) begin
    if (srst || !actv) begin
      ovSt <= 1'b0;
      uvSt <= 1'b0;
      twSt <= 1'b0;
      tsdSt <= 1'b0;
      ocSt <= '0;
      olSt <= '0;
    end else begin
      ovSt <= fLvl[0] || (ovSt && !clrReq);
      uvSt <= fLvl[1] || (uvSt && !clrReq);
      twSt <= fLvl[2] || (twSt && !clrReq);
      tsdSt <= fLvl[3] || (tsdSt && !(clrReq && coolS));
      ocSt <= fLvl[4 +: NO] | (ocSt & ~{NO{clrReq}});
      olSt <= fLvl[4 + NO +: NO] | (olSt & ~{NO{clrReq}});
    end
  end

  always_comb begin
    stat0 = '0;
    stat1 = '0;
    stat0[aoc_pkg::OC_LO +: NO] = ocSt;
    stat0[aoc_pkg::UV_BIT] = uvSt;
    stat0[aoc_pkg::OV_BIT] = ovSt;
    stat0[aoc_pkg::TW_BIT] = twSt;
    stat1[aoc_pkg::OL_LO +: NO] = olSt;
    stat1[aoc_pkg::TSD_BIT] = tsdSt;
    stat0[aoc_pkg::FAULT_BIT] = |{stat0, stat1};
    stat1[aoc_pkg::FAULT_BIT] = stat0[aoc_pkg::FAULT_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overcurrent recovery. A retry whose fault persists trips the filter again,
  // so the output runs at a low duty cycle instead of staying latched off.
  logic [RW-1:0] recCnt [NO];
  logic [NO-1:0] ocBlk;
  for (genvar i = 0; i < NO; i++) begin : g_rec
    always_ff @(posedge sys_clk) begin
      if (srst || !actv) begin
        recCnt[i] <= '0;
      end else if (fHit[4 + i]) begin
        recCnt[i] <= ctrl1[aoc_pkg::REC_LONG_BIT] ? RW'(RECOV_LONG_CYC) : RW'(RECOV_SHORT_CYC);
      end else if (recCnt[i] != '0) begin
        recCnt[i] <= recCnt[i] - RW'(1);
      end
    end
    assign ocBlk[i] = ctrl1[aoc_pkg::OC_REC_LO + i] ? (recCnt[i] != '0) || fLvl[4 + i] : ocSt[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output enables and gating. Warning and open load feed only status.
  logic supBlk;
  logic [NO-1:0] drvEn;
  logic [NO-1:0] gate;
  assign supBlk = fLvl[0] || fLvl[1] ||
                  (ctrl0[aoc_pkg::SUP_RECDIS_BIT] && (ovSt || uvSt));
  for (genvar o = 0; o < NO; o++) begin : g_en
    assign drvEn[o] = actv && !supBlk && !tsdSt && !ocBlk[o];
    assign gate[o] = !ctrl1[aoc_pkg::PWM_EN_LO + o] || (o == 8 || o == 9 ? pulseB : pulseA);
  end

  aoc_bridge_if bif [NB] ();
  for (genvar b = 0; b < NB; b++) begin : g_br
    assign bif[b].reqLs = ctrl0[aoc_pkg::DRV_CMD_LO + 2 * b] && drvEn[b] && gate[b];
    assign bif[b].reqHs = ctrl0[aoc_pkg::DRV_CMD_LO + 2 * b + 1] && drvEn[b] && gate[b];
    aoc_xbridge u_xb (
      .sys_clk(sys_clk),
      .srst(srst),
      .br(bif[b])
    );
    assign highSideTransistor[b] = bif[b].hsOn;
    assign lowSideTransistor[b] = bif[b].lsOn;
    assign highSideFastOff[b] = bif[b].hsFast;
    assign lowSideFastOff[b] = bif[b].lsFast;
    assign drvOn[b] = bif[b].hsOn || bif[b].lsOn;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      highsideOutput <= '0;
    end else begin
      for (int j = 0; j < NH; j++) begin
        highsideOutput[j] <= ctrl0[aoc_pkg::HSD_CMD_LO + j] && drvEn[NB + j] && gate[NB + j];
      end
    end
  end
  assign drvOn[NO-1:NB] = highsideOutput;

  ////////////////////////////////////////////////////////////////////////////
  // Current monitor mux. The shared pin turns input when outputs nine or ten
  // take pulse gating, so the monitor is lost while the second input is used.
  function automatic logic [3:0] monOutput(input logic [1:0] sel, input logic last);
    if (last) begin
      monOutput = 4'hb;
    end else begin
      case (sel)
        2'b00: monOutput = 4'h1;
        2'b01: monOutput = 4'h4;
        2'b10: monOutput = 4'h5;
        default: monOutput = 4'h6;
      endcase
    end
  endfunction : monOutput

  logic monDrive;
  assign monDrive = actv && !ctrl1[aoc_pkg::PWM_EN_LO + 8] && !ctrl1[aoc_pkg::PWM_EN_LO + 9];
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      monitorSelect <= 4'h0;
      monitorPulseSharedPinOut <= 1'b0;
      monitorPulseSharedPinOe_n <= 1'b1;
    end else begin
      monitorSelect <= actv ? monOutput(ctrl0[aoc_pkg::MON_SEL_LO +: 2],
                                        ctrl0[aoc_pkg::MON_LAST_BIT]) : 4'h0;
      monitorPulseSharedPinOut <= monDrive;
      monitorPulseSharedPinOe_n <= !monDrive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] ovRun;
  always_ff @(posedge sys_clk) begin
    if (srst || !syncB[0]) begin
      ovRun <= 16'h0000;
    end else if (ovRun != 16'hffff) begin
      ovRun <= ovRun + 16'h0001;
    end
  end
  sequence s_standby;
    !actv ##1 !actv;
  endsequence
  property p_standby_off;
    @(posedge sys_clk) disable iff (srst) s_standby |-> highsideOutput == '0 && monitorPulseSharedPinOe_n;
  endproperty
  a_standby_off: assert property (p_standby_off) else $error("output on in standby");
  property p_standby_clr;
    @(posedge sys_clk) disable iff (srst) !actv |=> stat0 == '0 && ctrl1 == '0;
  endproperty
  a_standby_clr: assert property (p_standby_clr) else $error("latch kept in standby");
  property p_wake;
    @(posedge sys_clk) disable iff (srst) wrCtrl0 && pwdata[aoc_pkg::ACTIVE_BIT] |=> actv;
  endproperty
  a_wake: assert property (p_wake) else $error("active mode not entered");
  property p_ov_filter;
    @(posedge sys_clk) disable iff (srst) $rose(ovSt) |-> $past(ovRun) >= aoc_pkg::DIAG_CYC;
  endproperty
  a_ov_filter: assert property (p_ov_filter) else $error("overvoltage flagged early");
  property p_tsd_off;
    @(posedge sys_clk) disable iff (srst) tsdSt ##1 tsdSt |=> highsideOutput == '0;
  endproperty
  a_tsd_off: assert property (p_tsd_off) else $error("output on in shutdown");
  property p_ov_off;
    @(posedge sys_clk) disable iff (srst) fLvl[0] |=> highsideOutput == '0;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("output on in overvoltage");
  property p_oc_latch;
    @(posedge sys_clk) disable iff (srst)
      ocSt[6] && !ctrl1[aoc_pkg::OC_REC_LO + 6] |=> !highsideOutput[0];
  endproperty
  a_oc_latch: assert property (p_oc_latch) else $error("overcurrent output on");
  property p_pwm;
    @(posedge sys_clk) disable iff (srst) ctrl1[aoc_pkg::PWM_EN_LO + 10] && !pulseA |=> !highsideOutput[4];
  endproperty
  a_pwm: assert property (p_pwm) else $error("pulse gate ignored");
  property p_recdis;
    @(posedge sys_clk) disable iff (srst) ctrl0[aoc_pkg::SUP_RECDIS_BIT] && uvSt |=> highsideOutput == '0;
  endproperty
  a_recdis: assert property (p_recdis) else $error("restart despite recovery disable");
  property p_mon;
    @(posedge sys_clk) disable iff (srst)
      actv && ctrl0[21:18] == 4'h1 |=> monitorSelect == 4'h4;
  endproperty
  a_mon: assert property (p_mon) else $error("monitor select wrong");
endmodule : aoc_ctrl

//--- sim/aoc_mcu_model.sv
// Microcontroller model that masters the register bus.
`timescale 1ns/1ps
module aoc_mcu_model (
  // Clock
  input wire logic sys_clk,
  // Bus request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // Bus answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    // Released lines show a changed value so stale data is never mistaken for valid.
    {psel, penable} <= 2'h0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
  task automatic clr(input logic [23:0] c);
    logic [31:0] q;
    logic e;
    xfer(1'b1, 8'h00, {8'h00, c | 24'h400000}, q, e);
  endtask : clr
endmodule : aoc_mcu_model

//--- sim/test_actuator_output_protection_ctrl.sv
// Self-checking bench of the output control and protection logic.
`timescale 1ns/1ps
module test_actuator_output_protection_ctrl;
  logic sys_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic ovC, uvC, twC, tsdC, coolC, pwmA, pwmSet, pinIn, pinOut, pinOe_n, e, run;
  logic [10:0] ocC, olC;
  logic [3:0] monSel;
  logic [5:0] hsT, lsT, hsF, lsF;
  logic [4:0] hsOut;
  logic [23:0] c0;
  int errCount, checks, seed, k;
  aoc_mcu_model u_aoc_mcu_model (.sys_clk(sys_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  aoc_ctrl #(.OPEN_LOAD_CYC(50), .RECOV_SHORT_CYC(40), .RECOV_LONG_CYC(80)) u_aoc_ctrl (
    .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .overvoltageCmp(ovC), .undervoltageCmp(uvC), .tempWarnCmp(twC),
    .thermalShutdownCmp(tsdC), .thermalCooledCmp(coolC), .overcurrentCmp(ocC),
    .openLoadCmp(olC), .pulseGateInputA(pwmA), .monitorPulseSharedPinIn(pinIn),
    .monitorPulseSharedPinOut(pinOut), .monitorPulseSharedPinOe_n(pinOe_n),
    .monitorSelect(monSel), .highSideTransistor(hsT), .lowSideTransistor(lsT),
    .highSideFastOff(hsF), .lowSideFastOff(lsF), .highsideOutput(hsOut));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // The pulse input toggles with a 64 ns period while run is high, else follows pwmSet.
  initial begin
    pwmA = 1'b0;
    forever begin
      @(posedge sys_clk);
      if (run) begin
        repeat (3) @(posedge sys_clk);
      end
      pwmA <= run ? ~pwmA : pwmSet;
    end
  end
  // The tests need about 31,000 cycles, so this limit leaves ample margin.
  initial begin
    #500000;
    errCount++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errCount);
    if (errCount == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_aoc_mcu_model.xfer(1'b1, a, d, q, e);
    cyc(3);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    u_aoc_mcu_model.xfer(1'b0, a, 32'h00000000, q, e);
  endtask : rd
  function automatic logic [31:0] hsExp(input logic [23:0] c);
    return 32'(c[17:13]);
  endfunction : hsExp
  function automatic logic [31:0] monExp(input int s);
    return (s == 4) ? 32'hb : (s == 0) ? 32'h1 : 32'(s + 3);
  endfunction : monExp
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hd1abc9b0;
    {errCount, checks, run} = 0;
    srst = 1'b1;
    {ovC, uvC, twC, tsdC, pwmSet, pinIn} = 6'h00;
    coolC = 1'b1;
    {ocC, olC} = 22'h000000;
    cyc(10);
    srst <= 1'b0;
    cyc(3);
    chk("rst", {hsOut, hsT, lsT, pinOe_n}, 32'h1);
    rd(8'h40);
    chk("unmapped", {q[30:0], e}, 32'h1);
    repeat (4) begin
      c0 = {1'b1, 5'h00, 5'($random(seed)), 13'h0000};
      wr(8'h00, c0);
      chk("hs", hsOut, hsExp(c0));
    end
    wr(8'h00, 24'h82a000);
    wr(8'h04, 32'ha80);
    run = 1'b1;
    cyc(200);
    run = 1'b0;
    for (k = 0; k < 2; k++) begin
      pwmSet <= k[0];
      pinIn <= ~k[0];
      cyc(10);
      chk("pwm", hsOut, k ? 32'h11 : 32'h4);
    end
    wr(8'h04, 32'h0);
    c0 = 24'h83e000;
    wr(8'h00, c0);
    ocC <= 11'h040;
    cyc(4100);
    rd(8'h08);
    chk("oc", {hsOut, q[7], q[0]}, 32'h7b);
    ocC <= 11'h000;
    cyc(20);
    chk("latch", hsOut, 32'h1e);
    u_aoc_mcu_model.clr(c0);
    cyc(3);
    rd(8'h08);
    chk("clr", {hsOut, q[23:0]}, {3'h0, 5'h1f, 24'h0});
    for (k = 0; k < 2; k++) begin
      ocC <= 11'h040;
      cyc(3000);
      ocC <= 11'h000;
      cyc(4);
    end
    chk("flt", hsOut, 32'h1f);
    twC <= 1'b1;
    olC <= 11'h040;
    cyc(4100);
    rd(8'h08);
    chk("tw", {hsOut, q[22]}, 32'h3f);
    rd(8'h0c);
    chk("ol", q[7], 32'h1);
    twC <= 1'b0;
    olC <= 11'h000;
    u_aoc_mcu_model.clr(c0);
    tsdC <= 1'b1;
    coolC <= 1'b0;
    cyc(4100);
    chk("tsd", hsOut, 32'h0);
    tsdC <= 1'b0;
    cyc(6);
    u_aoc_mcu_model.clr(c0);
    cyc(3);
    chk("hot", hsOut, 32'h0);
    coolC <= 1'b1;
    cyc(4);
    u_aoc_mcu_model.clr(c0);
    cyc(3);
    chk("cool", hsOut, 32'h1f);
    for (k = 0; k < 2; k++) begin
      c0[20] = k[0];
      wr(8'h00, c0 | 24'h400000);
      if (k) uvC <= 1'b1;
      else ovC <= 1'b1;
      cyc(4100);
      chk("sup", hsOut, 32'h0);
      {ovC, uvC} <= 2'h0;
      cyc(10);
      chk("back", hsOut, k ? 32'h0 : 32'h1f);
    end
    u_aoc_mcu_model.clr(c0);
    cyc(3);
    chk("rec", hsOut, 32'h1f);
    wr(8'h04, 32'h40000);
    ocC <= 11'h040;
    cyc(4010);
    ocC <= 11'h000;
    cyc(20);
    chk("retry", hsOut, 32'h1e);
    cyc(30);
    chk("retried", hsOut, 32'h1f);
    for (k = 0; k < 5; k++) begin
      wr(8'h00, {2'h2, k == 4, 1'b0, 2'(k), 18'h0});
      chk("mon", {pinOe_n, pinOut, monSel}, 32'h10 | monExp(k));
    end
    wr(8'h00, 24'h800002);
    chk("ls", {hsT[0], lsT[0]}, 32'h1);
    wr(8'h00, 24'h800004);
    cyc(50);
    chk("dead", {hsT[0], lsT[0]}, 32'h0);
    cyc(aoc_pkg::XPROT_CYC - 51);
    chk("fast", {hsT[0], lsT[0], hsF[0], lsF[0]}, 32'h1);
    cyc(26);
    chk("hson", {hsT[0], lsT[0]}, 32'h2);
    wr(8'h00, 32'h0);
    chk("stby", {hsOut, hsT, lsT, monSel, pinOut, pinOe_n}, 32'h1);
    cyc(130);
    print_verdict();
  end
endmodule : test_actuator_output_protection_ctrl
